// ===== verilog/ipr_regs.vh
/*
 constants for the interrupt priority register slice: register indexes,
 field positions, reset values. assumes a 16-bit register port.
*/
`ifndef IPR_REGS_VH
`define IPR_REGS_VH

`define IPR_ADDR_W        4
`define IPR_IDX_PRI11     4'h0
`define IPR_IDX_PRI12     4'h1
`define IPR_IDX_PRI13     4'h2
`define IPR_IDX_PRI14     4'h3
`define IPR_IDX_PRI15     4'h4
`define IPR_IDX_PRI16     4'h5
`define IPR_IDX_PRI17     4'h6
`define IPR_IDX_STATUS    4'h7
`define IPR_NUM_PRI       7

`define IPR_FLD_HI        14
`define IPR_FLD_MH        10
`define IPR_FLD_ML        6
`define IPR_FLD_LO        2

`define IPR_PRI_RESET     3'h4
`define IPR_PRI_OFF       3'h0
`define IPR_PRI11_MASK    16'h7_707
`define IPR_PRI14_MASK    16'h0_007
`define IPR_PRI15_MASK    16'h0_070
`define IPR_PRI16_MASK    16'h0_770
`define IPR_FULL_MASK     16'h7_777
`define IPR_PRI_RST_WORD  16'h4_444

`define IPR_LVL_HI        11
`define IPR_LVL_LO        8
`define IPR_VEC_HI        6
`define IPR_VEC_LO        0
`define IPR_VEC_BASE      8'h0_8

`endif

// ===== verilog/ipr_status_store.v
/*
 small register store for the status word: level and vector, captured on
 an interrupt take, read data come out of a register.
 assumes the same clock, reset and enable as the priority slice.
*/
`timescale 1ns/10ps
module ipr_status_store (
   // clock and reset
   input  wire        clock,
   input  wire        resetn,
   input  wire        clockEn,
   // capture side
   input  wire        capture,
   input  wire [3:0]  levelIn,
   input  wire [6:0]  vectorIn,
   // read side
   output reg  [15:0] statusWord_reg
);
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         statusWord_reg <= 16'h0_000;
      end else if (clockEn && capture) begin
         statusWord_reg <= {4'h0, levelIn, 1'b0, vectorIn};
      end
   end
endmodule

// ===== verilog/ipr_priority_slice.v
/*
 upper priority control registers of the interrupt controller and the
 status register reporting new cpu level and pending vector.
 assumes a synchronous register port with read data one cycle after
 the read strobe, and an arbiter outside that signals interrupt takes.
*/
// Functional notes
// - field code equals priority, 111 highest
// - field 000 disables the source entirely
// - unassigned bits always read zero
// - priority fields reset to level 4
// - register 11 holds timer6, dma4, outcmp8
// - register 12 holds timer8, i2c2 master/slave, timer7
// - register 14 holds only can2 event
// - register 15 holds only dma5 at 6-4
// - register 17 holds can tx, dma7, dma6
// - status bits 11-8 report new cpu level
// - status bits 6-0 report pending vector
`timescale 1ns/10ps
`include "ipr_regs.vh"
module ipr_priority_slice (
   // clock and reset
   input  wire        clock,
   input  wire        resetn,
   input  wire        clockEn,
   // register port
   input  wire [3:0]  regAddr,
   input  wire [15:0] regWrData,
   input  wire        regWrite,
   input  wire        regRead,
   output reg  [15:0] regRdData_reg,
   // interrupt take from the arbiter
   input  wire        irqTaken,
   input  wire [3:0]  takenLevel,
   input  wire [6:0]  takenVector,
   // priorities to the arbiter, 0 means disabled
   output reg  [2:0]  timer6_priority_reg,
   output reg  [2:0]  dma_ch4_done_priority_reg,
   output reg  [2:0]  outcmp8_priority_reg,
   output reg  [2:0]  timer8_priority_reg,
   output reg  [2:0]  i2c2_master_priority_reg,
   output reg  [2:0]  i2c2_slave_priority_reg,
   output reg  [2:0]  timer7_priority_reg,
   output reg  [2:0]  can2_rx_ready_priority_reg,
   output reg  [2:0]  ext_irq4_priority_reg,
   output reg  [2:0]  ext_irq3_priority_reg,
   output reg  [2:0]  timer9_priority_reg,
   output reg  [2:0]  can2_event_priority_reg,
   output reg  [2:0]  dma_ch5_done_priority_reg,
   output reg  [2:0]  uart2_error_priority_reg,
   output reg  [2:0]  uart1_error_priority_reg,
   output reg  [2:0]  can2_tx_request_priority_reg,
   output reg  [2:0]  can1_tx_request_priority_reg,
   output reg  [2:0]  dma_ch7_done_priority_reg,
   output reg  [2:0]  dma_ch6_done_priority_reg,
   // per-source enable from the priority field
   output reg  [18:0] sourceEnable_reg,
   // status fields
   output reg  [3:0]  new_cpu_level_reg,
   output reg  [6:0]  pending_vector_number_reg
);
   // implemented-bit mask for each priority register
   function [15:0] implMask;
      input [3:0] idx;
      begin
         case (idx)
            `IPR_IDX_PRI11: implMask = `IPR_PRI11_MASK;
            `IPR_IDX_PRI12: implMask = `IPR_FULL_MASK;
            `IPR_IDX_PRI13: implMask = `IPR_FULL_MASK;
            `IPR_IDX_PRI14: implMask = `IPR_PRI14_MASK;
            `IPR_IDX_PRI15: implMask = `IPR_PRI15_MASK;
            `IPR_IDX_PRI16: implMask = `IPR_PRI16_MASK;
            `IPR_IDX_PRI17: implMask = `IPR_FULL_MASK;
            default:        implMask = 16'h0_000;
         endcase
      end
   endfunction

   // field extract: a priority field in a given slot of a word, slot 0 lowest
   function [2:0] field;
      input [15:0] word;
      input [1:0]  slot;
      begin
         case (slot)
            2'd3:    field = word[`IPR_FLD_HI:`IPR_FLD_HI-2];
            2'd2:    field = word[`IPR_FLD_MH:`IPR_FLD_MH-2];
            2'd1:    field = word[`IPR_FLD_ML:`IPR_FLD_ML-2];
            default: field = word[`IPR_FLD_LO:0];
         endcase
      end
   endfunction

   reg  [15:0] priWord_reg [0:`IPR_NUM_PRI-1];
   wire [15:0] statusWord;
   wire        capture;
   reg  [15:0] regRdData_next;
   // next values of the output registers
   reg  [2:0]  timer6_priority_next;
   reg  [2:0]  dma_ch4_done_priority_next;
   reg  [2:0]  outcmp8_priority_next;
   reg  [2:0]  timer8_priority_next;
   reg  [2:0]  i2c2_master_priority_next;
   reg  [2:0]  i2c2_slave_priority_next;
   reg  [2:0]  timer7_priority_next;
   reg  [2:0]  can2_rx_ready_priority_next;
   reg  [2:0]  ext_irq4_priority_next;
   reg  [2:0]  ext_irq3_priority_next;
   reg  [2:0]  timer9_priority_next;
   reg  [2:0]  can2_event_priority_next;
   reg  [2:0]  dma_ch5_done_priority_next;
   reg  [2:0]  uart2_error_priority_next;
   reg  [2:0]  uart1_error_priority_next;
   reg  [2:0]  can2_tx_request_priority_next;
   reg  [2:0]  can1_tx_request_priority_next;
   reg  [2:0]  dma_ch7_done_priority_next;
   reg  [2:0]  dma_ch6_done_priority_next;
   reg  [3:0]  new_cpu_level_next;
   reg  [6:0]  pending_vector_number_next;
   // all source priorities side by side, in output port order, first source lowest
   wire [56:0] priVec;
   wire [18:0] sourceEnable_next;

   // each register keeps only its implemented bits, so unused ones read 0
   genvar g;
   generate
      for (g = 0; g < `IPR_NUM_PRI; g = g + 1) begin : gPri
         localparam [3:0] IDX = g;
         always @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               priWord_reg[g] <= `IPR_PRI_RST_WORD & implMask(IDX);
            end else if (clockEn && regWrite && regAddr == IDX) begin
               priWord_reg[g] <= regWrData & implMask(IDX);
            end
         end
      end
   endgenerate

   // a take from the arbiter loads the status store
   assign capture = irqTaken;

   ipr_status_store uStatus (
      .clock          (clock),
      .resetn         (resetn),
      .clockEn        (clockEn),
      .capture        (capture),
      .levelIn        (takenLevel),
      .vectorIn       (takenVector),
      .statusWord_reg (statusWord)
   );

   always @* begin
      regRdData_next = 16'h0_000;
      if (regAddr == `IPR_IDX_STATUS) begin
         regRdData_next = statusWord;
      end else if (regAddr < `IPR_NUM_PRI) begin
         regRdData_next = priWord_reg[regAddr[2:0]];
      end
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         regRdData_reg <= 16'h0_000;
      end else if (clockEn) begin
         regRdData_reg <= regRead ? regRdData_next : 16'h0_000;
      end
   end

   // the field value is the priority itself, no remapping, so the arbiter
   // compares codes directly
   always @* begin
      timer6_priority_next          = field(priWord_reg[0], 2'd3);
      dma_ch4_done_priority_next    = field(priWord_reg[0], 2'd2);
      outcmp8_priority_next         = field(priWord_reg[0], 2'd0);
      timer8_priority_next          = field(priWord_reg[1], 2'd3);
      i2c2_master_priority_next     = field(priWord_reg[1], 2'd2);
      i2c2_slave_priority_next      = field(priWord_reg[1], 2'd1);
      timer7_priority_next          = field(priWord_reg[1], 2'd0);
      can2_rx_ready_priority_next   = field(priWord_reg[2], 2'd3);
      ext_irq4_priority_next        = field(priWord_reg[2], 2'd2);
      ext_irq3_priority_next        = field(priWord_reg[2], 2'd1);
      timer9_priority_next          = field(priWord_reg[2], 2'd0);
      can2_event_priority_next      = field(priWord_reg[3], 2'd0);
      dma_ch5_done_priority_next    = field(priWord_reg[4], 2'd1);
      uart2_error_priority_next     = field(priWord_reg[5], 2'd2);
      uart1_error_priority_next     = field(priWord_reg[5], 2'd1);
      can2_tx_request_priority_next = field(priWord_reg[6], 2'd3);
      can1_tx_request_priority_next = field(priWord_reg[6], 2'd2);
      dma_ch7_done_priority_next    = field(priWord_reg[6], 2'd1);
      dma_ch6_done_priority_next    = field(priWord_reg[6], 2'd0);
      new_cpu_level_next            = statusWord[`IPR_LVL_HI:`IPR_LVL_LO];
      pending_vector_number_next    = statusWord[`IPR_VEC_HI:`IPR_VEC_LO];
   end

   assign priVec = {
      dma_ch6_done_priority_next,
      dma_ch7_done_priority_next,
      can1_tx_request_priority_next,
      can2_tx_request_priority_next,
      uart1_error_priority_next,
      uart2_error_priority_next,
      dma_ch5_done_priority_next,
      can2_event_priority_next,
      timer9_priority_next,
      ext_irq3_priority_next,
      ext_irq4_priority_next,
      can2_rx_ready_priority_next,
      timer7_priority_next,
      i2c2_slave_priority_next,
      i2c2_master_priority_next,
      timer8_priority_next,
      outcmp8_priority_next,
      dma_ch4_done_priority_next,
      timer6_priority_next};

   // a zero field keeps the source away from the processor
   localparam NUM_SRC = 19;
   genvar s;
   generate
      for (s = 0; s < NUM_SRC; s = s + 1) begin : gEn
         assign sourceEnable_next[s] = (priVec[3*s +: 3] != `IPR_PRI_OFF);
      end
   endgenerate

   // outputs follow the stored words one cycle later, one block per register
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         timer6_priority_reg       <= `IPR_PRI_RESET;
         dma_ch4_done_priority_reg <= `IPR_PRI_RESET;
         outcmp8_priority_reg      <= `IPR_PRI_RESET;
      end else if (clockEn) begin
         timer6_priority_reg       <= timer6_priority_next;
         dma_ch4_done_priority_reg <= dma_ch4_done_priority_next;
         outcmp8_priority_reg      <= outcmp8_priority_next;
      end
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         timer8_priority_reg      <= `IPR_PRI_RESET;
         i2c2_master_priority_reg <= `IPR_PRI_RESET;
         i2c2_slave_priority_reg  <= `IPR_PRI_RESET;
         timer7_priority_reg      <= `IPR_PRI_RESET;
      end else if (clockEn) begin
         timer8_priority_reg      <= timer8_priority_next;
         i2c2_master_priority_reg <= i2c2_master_priority_next;
         i2c2_slave_priority_reg  <= i2c2_slave_priority_next;
         timer7_priority_reg      <= timer7_priority_next;
      end
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         can2_rx_ready_priority_reg <= `IPR_PRI_RESET;
         ext_irq4_priority_reg      <= `IPR_PRI_RESET;
         ext_irq3_priority_reg      <= `IPR_PRI_RESET;
         timer9_priority_reg        <= `IPR_PRI_RESET;
      end else if (clockEn) begin
         can2_rx_ready_priority_reg <= can2_rx_ready_priority_next;
         ext_irq4_priority_reg      <= ext_irq4_priority_next;
         ext_irq3_priority_reg      <= ext_irq3_priority_next;
         timer9_priority_reg        <= timer9_priority_next;
      end
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         can2_event_priority_reg <= `IPR_PRI_RESET;
      end else if (clockEn) begin
         can2_event_priority_reg <= can2_event_priority_next;
      end
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         dma_ch5_done_priority_reg <= `IPR_PRI_RESET;
      end else if (clockEn) begin
         dma_ch5_done_priority_reg <= dma_ch5_done_priority_next;
      end
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         uart2_error_priority_reg <= `IPR_PRI_RESET;
         uart1_error_priority_reg <= `IPR_PRI_RESET;
      end else if (clockEn) begin
         uart2_error_priority_reg <= uart2_error_priority_next;
         uart1_error_priority_reg <= uart1_error_priority_next;
      end
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         can2_tx_request_priority_reg <= `IPR_PRI_RESET;
         can1_tx_request_priority_reg <= `IPR_PRI_RESET;
         dma_ch7_done_priority_reg    <= `IPR_PRI_RESET;
         dma_ch6_done_priority_reg    <= `IPR_PRI_RESET;
      end else if (clockEn) begin
         can2_tx_request_priority_reg <= can2_tx_request_priority_next;
         can1_tx_request_priority_reg <= can1_tx_request_priority_next;
         dma_ch7_done_priority_reg    <= dma_ch7_done_priority_next;
         dma_ch6_done_priority_reg    <= dma_ch6_done_priority_next;
      end
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         new_cpu_level_reg         <= 4'h0;
         pending_vector_number_reg <= 7'h00;
      end else if (clockEn) begin
         new_cpu_level_reg         <= new_cpu_level_next;
         pending_vector_number_reg <= pending_vector_number_next;
      end
   end

   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         sourceEnable_reg <= 19'h7_FFFF;
      end else if (clockEn) begin
         sourceEnable_reg <= sourceEnable_next;
      end
   end
endmodule

// ===== tb/ipr_slice_monitor.sv
/* assertions on the priority slice ports.
   assumes one clock domain and a bind to ipr_priority_slice. */
`timescale 1ns/10ps
module ipr_slice_monitor (
   // clock and reset
   input logic        clock,
   input logic        resetn,
   input logic        clockEn,
   // register port
   input logic [3:0]  regAddr,
   input logic [15:0] regWrData,
   input logic        regWrite,
   input logic        regRead,
   input logic [15:0] regRdData_reg,
   // take port and outputs
   input logic        irqTaken,
   input logic [3:0]  takenLevel,
   input logic [6:0]  takenVector,
   input logic [2:0]  dma_ch5_done_priority_reg,
   input logic [18:0] sourceEnable_reg,
   input logic [3:0]  new_cpu_level_reg,
   input logic [6:0]  pending_vector_number_reg
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   wire rd = clockEn && regRead;
   wire wr = clockEn && regWrite;
   chk_read_idle_zero: assert property (clockEn && !regRead |=> regRdData_reg == 16'h0_000)
      else $error("read data not zero outside a read");
   chk_pri11_unused: assert property (rd && regAddr == 4'h0 |=> (regRdData_reg & 16'h8_8F8) == 16'h0_000)
      else $error("unused bit set in first register");
   chk_pri14_unused: assert property (rd && regAddr == 4'h3 |=> (regRdData_reg & 16'hF_FF8) == 16'h0_000)
      else $error("unused bit set in can2 event register");
   chk_pri15_unused: assert property (rd && regAddr == 4'h4 |=> (regRdData_reg & 16'hF_F8F) == 16'h0_000)
      else $error("unused bit set in dma5 register");
   chk_reset_level: assert property ($rose(resetn) |-> dma_ch5_done_priority_reg == 3'h4 && &sourceEnable_reg)
      else $error("priority not at level four after reset");
   chk_zero_disables: assert property (wr && regAddr == 4'h4 && regWrData[6:4] == 3'h0
      |-> ##[2:3] dma_ch5_done_priority_reg == 3'h0 ##[0:1] !sourceEnable_reg[12])
      else $error("zero priority left source enabled");
   chk_take_capture: assert property (clockEn && irqTaken |-> ##2 new_cpu_level_reg == $past(takenLevel, 2)
      && pending_vector_number_reg == $past(takenVector, 2))
      else $error("taken level or vector not reported");
   chk_status_read: assert property (rd && regAddr == 4'h7 && !irqTaken
      |=> regRdData_reg == {4'h0, new_cpu_level_reg, 1'b0, pending_vector_number_reg})
      else $error("status word differs from reported fields");
   chk_status_ro: assert property (wr && regAddr == 4'h7 && !irqTaken && !$past(irqTaken)
      |=> $stable(new_cpu_level_reg) && $stable(pending_vector_number_reg))
      else $error("status changed by a write");
   cover property (wr ##1 rd);
   cover property (irqTaken [*2]);
   cover property (rd && regAddr == 4'h7);
   cover property (!clockEn ##1 clockEn);
endmodule

bind ipr_priority_slice ipr_slice_monitor monitor (.clock, .resetn, .clockEn, .regAddr, .regWrData, .regWrite,
   .regRead, .regRdData_reg, .irqTaken, .takenLevel, .takenVector, .dma_ch5_done_priority_reg,
   .sourceEnable_reg, .new_cpu_level_reg, .pending_vector_number_reg);

// ===== tb/test_ipr_priority_slice.sv
/* self-checking bench for the priority slice: reset words, field map,
   disable code, status capture, enable freeze. assumes clockEn is low only in the freeze task. */
`timescale 1ns/10ps
module test_ipr_priority_slice;
   logic        clock = 0, resetn = 0, regWrite = 0, regRead = 0, irqTaken = 0, clockEn = 1;
   logic [3:0]  regAddr = 4'h0, takenLevel = 4'h0;
   logic [6:0]  takenVector = 7'h00;
   logic [15:0] regWrData = 16'h0_000, rdVal;
   wire  [15:0] regRdData;
   wire  [2:0]  pri [0:27];
   wire  [18:0] srcEn;
   wire  [3:0]  newLevel;
   wire  [6:0]  pendVec;
   int          numErrors = 0, nCompared = 0;
   // index 7 is the status word, zero until the first take
   logic [15:0] mask [0:8] = '{16'h7_707, 16'h7_777, 16'h7_777, 16'h0_007, 16'h0_070,
                               16'h0_770, 16'h7_777, 16'h0_000, 16'h0_000};
   ipr_priority_slice dut (
      .clock(clock), .resetn(resetn), .clockEn(clockEn), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData_reg(regRdData), .irqTaken(irqTaken),
      .takenLevel(takenLevel), .takenVector(takenVector), .sourceEnable_reg(srcEn),
      .new_cpu_level_reg(newLevel), .pending_vector_number_reg(pendVec),
      .timer6_priority_reg(pri[3]), .dma_ch4_done_priority_reg(pri[2]), .outcmp8_priority_reg(pri[0]),
      .timer8_priority_reg(pri[7]), .i2c2_master_priority_reg(pri[6]), .i2c2_slave_priority_reg(pri[5]),
      .timer7_priority_reg(pri[4]), .can2_rx_ready_priority_reg(pri[11]), .ext_irq4_priority_reg(pri[10]),
      .ext_irq3_priority_reg(pri[9]), .timer9_priority_reg(pri[8]), .can2_event_priority_reg(pri[12]),
      .dma_ch5_done_priority_reg(pri[17]), .uart2_error_priority_reg(pri[22]),
      .uart1_error_priority_reg(pri[21]), .can2_tx_request_priority_reg(pri[27]),
      .can1_tx_request_priority_reg(pri[26]), .dma_ch7_done_priority_reg(pri[25]),
      .dma_ch6_done_priority_reg(pri[24]));
   always #12.5 clock = ~clock;
   task automatic check(string name, logic [18:0] exp, logic [18:0] got);
      nCompared++;
      if (got !== exp) begin
         numErrors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [15:0] d);
      @(posedge clock);
      regWrite <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clock);
      regWrite <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(logic [3:0] a);
      @(posedge clock);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clock);
      regRead <= 1'b0;
      #1 rdVal = regRdData;
   endtask
   task automatic reset_values;
      for (int r = 0; r < 9; r++) begin
         rd(r[3:0]);
         check("reset word", 16'h4_444 & mask[r], rdVal);
      end
   endtask
   // every code in every field, set bits in unused places, then a distinct code per field
   task automatic field_sweep;
      logic [15:0] w;
      for (int k = 0; k < 9; k++) begin
         w = (k < 8) ? {4{1'b1, k[2:0]}} : 16'hF_AD1;
         for (int r = 0; r < 9; r++) wr(r[3:0], w);
         repeat (2) @(posedge clock);
         check("source enables", {19{w[2:0] != 3'h0}}, srcEn);
         for (int i = 0; i < 28; i++)
            if (mask[i / 4][i % 4 * 4 +: 3] != 3'h0) check("priority output", w[i % 4 * 4 +: 3], pri[i]);
         for (int r = 0; r < 9; r++) begin
            rd(r[3:0]);
            check("field word", w & mask[r], rdVal);
         end
      end
   endtask
   task automatic take2(logic [3:0] l1, logic [6:0] v1, logic [3:0] l2, logic [6:0] v2);
      @(posedge clock);
      irqTaken <= 1'b1;
      takenLevel <= l1;
      takenVector <= v1;
      @(posedge clock);
      takenLevel <= l2;
      takenVector <= v2;
      @(posedge clock);
      irqTaken <= 1'b0;
      repeat (2) @(posedge clock);
      check("cpu level", l2, newLevel);
      check("pending vector", v2, pendVec);
      rd(4'h7);
      check("status word", {4'h0, l2, 1'b0, v2}, rdVal);
   endtask
   task automatic take_capture;
      take2(4'hF, 7'h7F, 4'h5, 7'h2A);
      wr(4'h7, 16'hF_FFF);
      rd(4'h7);
      check("status after write", 16'h0_52A, rdVal);
      take2(4'hF, 7'h7F, 4'hF, 7'h7F);
   endtask
   // enable bits follow output port order; a low enable must freeze writes, read data and takes
   task automatic enable_freeze;
      wr(4'h6, 16'h0_000);
      repeat (2) @(posedge clock);
      check("source enables", 19'h0_7FFF, srcEn);
      @(posedge clock);
      clockEn <= 1'b0;
      irqTaken <= 1'b1;
      takenLevel <= 4'h1;
      @(posedge clock);
      irqTaken <= 1'b0;
      wr(4'h6, 16'h7_777);
      rd(4'h6);
      check("frozen read data", 16'h0_000, rdVal);
      check("frozen enables", 19'h0_7FFF, srcEn);
      check("frozen level", 4'hF, newLevel);
      @(posedge clock);
      clockEn <= 1'b1;
      rd(4'h6);
      check("word after freeze", 16'h0_000, rdVal);
      rd(4'h7);
      check("status after freeze", 16'h0_F7F, rdVal);
   endtask
   task automatic tally_and_finish;
      if (numErrors == 0 && nCompared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clock);
      resetn <= 1'b1;
      reset_values();
      field_sweep();
      take_capture();
      enable_freeze();
      tally_and_finish();
   end
   // the tests need well under a thousand cycles
   initial begin
      repeat (20000) @(posedge clock);
      numErrors++;
      tally_and_finish();
   end
endmodule
